// File: logic/cbh_card_buffer_head_one.v
// Head-one control for the read-punch half of the drum card buffer
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/10ps
`include "cbh_consts.vh"
module cbh_card_buffer_head_one (
  // Clock and reset
  input wire i_clk,
  input wire i_rstn,
  // AXI4-Lite write address
  input wire i_awvalid,
  output wire o_awready,
  input wire [7:0] i_awaddr,
  // AXI4-Lite write data
  input wire i_wvalid,
  output wire o_wready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  // AXI4-Lite write response
  output wire o_bvalid,
  input wire i_bready,
  output wire [1:0] o_bresp,
  // AXI4-Lite read address
  input wire i_arvalid,
  output wire o_arready,
  input wire [7:0] i_araddr,
  // AXI4-Lite read data
  output wire o_rvalid,
  input wire i_rready,
  output wire [31:0] o_rdata,
  output wire [1:0] o_rresp,
  // Drum timing pins
  input wire i_timing_msd_signal,
  input wire i_address_sample_phase,
  input wire i_write_set_phase,
  input wire i_write_clear_phase,
  input wire i_sentinel_first,
  input wire i_sentinel_second,
  input wire i_sentinel_third,
  input wire i_sentinel_fourth,
  input wire i_sentinel_fifth,
  // Row counter pins
  input wire i_row_upper_unprimed,
  input wire i_row_upper_primed,
  input wire i_row_lower_unprimed,
  input wire i_row_lower_primed,
  // Processor control pins
  input wire i_readout_set_level,
  input wire i_revolution_count_one,
  input wire i_punch_function,
  input wire i_output_word_read,
  input wire i_word_read_done,
  input wire i_write_pedestal,
  input wire i_write_input_gate,
  input wire i_head2_write_req,
  // Head indications
  output wire o_reader_half_under_head,
  output wire o_punch_half_under_head,
  output wire o_read_stop_level,
  // Flop states and strobes
  output wire o_write_ff,
  output wire o_read_ff,
  output reg o_group_step,
  output reg o_upper_half_store_strobe,
  // Gate enables
  output reg o_head1_punch_write,
  output reg o_head1_reader_gate,
  output reg o_head1_punch_gate,
  output reg o_head2_punch_read_gate,
  output reg o_head2_reader_rw_gate,
  output reg o_head2_write_gate,
  // Card unit sort request
  output wire o_sort_request
);

  // Address decode shared by both bus paths
  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a == `CBH_CTRL_OFF) | (a == `CBH_STAT_OFF) | (a == `CBH_CNT_OFF);
    end
  endfunction

  wire [`CBH_NPIN-1:0] pins;
  reg [`CBH_NPIN-1:0] s1_q;
  reg [`CBH_NPIN-1:0] s2_q;
  reg [`CBH_NPIN-1:0] s3_q;

  // Pin vector gathered for synchronising
  assign pins = {i_head2_write_req, i_write_input_gate, i_write_pedestal,
    i_word_read_done, i_output_word_read, i_punch_function,
    i_revolution_count_one, i_readout_set_level,
    i_row_lower_primed, i_row_lower_unprimed,
    i_row_upper_primed, i_row_upper_unprimed,
    i_sentinel_fifth, i_sentinel_fourth, i_sentinel_third,
    i_sentinel_second, i_sentinel_first,
    i_write_clear_phase, i_write_set_phase,
    i_address_sample_phase, i_timing_msd_signal};

  // Two-flop synchroniser plus edge stage
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      s1_q <= {`CBH_NPIN{1'b0}};
      s2_q <= {`CBH_NPIN{1'b0}};
      s3_q <= {`CBH_NPIN{1'b0}};
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  wire [`CBH_NPIN-1:0] rise;
  assign rise = s2_q & ~s3_q;

  // Named synchronised levels and edges
  wire msd_high = s2_q[0];
  wire sample_p = rise[1];
  wire wset_p = rise[2];
  wire wclr_p = rise[3];
  wire sen1 = s2_q[4];
  wire sen2 = s2_q[5];
  wire sen3 = s2_q[6];
  wire sen4 = s2_q[7];
  wire sen5_p = rise[8];
  wire row_uu = s2_q[9];
  wire row_up = s2_q[10];
  wire row_lu = s2_q[11];
  wire row_lp = s2_q[12];
  wire readout_p = rise[13];
  wire rev_one = s2_q[14];
  wire punch_fn = s2_q[15];
  wire out_word_p = rise[16];
  wire word_done_p = rise[17];
  wire pedestal = s2_q[18];
  wire wr_gate = s2_q[19];
  wire h2_wreq = s2_q[20];

  // Register state
  reg [`CBH_CTRL_W-1:0] ctrl_q;
  reg half_q;
  reg rdstop_q;
  reg write_q;
  reg read_q;
  reg [7:0] in_cnt_q;
  reg [7:0] xfer_cnt_q;
  reg clr_cnt_q;

  wire sense_en = ctrl_q[`CBH_C_SENSE];
  wire setup_en = ctrl_q[`CBH_C_SETUP];
  wire xfer_en = ctrl_q[`CBH_C_XFER];
  wire even_sel = ctrl_q[`CBH_C_EVEN] & ~ctrl_q[`CBH_C_ODD];
  wire odd_sel = ctrl_q[`CBH_C_ODD] & ~ctrl_q[`CBH_C_EVEN];

  // Software sort bit drives the card unit; it must be set before the deadline
  assign o_sort_request = ctrl_q[`CBH_C_SORT];

  // Head-half indicator sampled mid-word; a high digit line means digit 0
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      half_q <= 1'b0;
    end else if (sample_p) begin
      half_q <= ~msd_high;
    end
  end

  // Complementary half outputs, cleared means reader line low
  assign o_reader_half_under_head = half_q;
  assign o_punch_half_under_head = ~half_q;

  // Sentinel and row match per group selection
  wire even_hit = (sen3 & row_uu) | (sen4 & row_up) | (sen1 & row_lu) | (sen2 & row_lp);
  wire odd_hit = (sen1 & row_uu) | (sen2 & row_up) | (sen3 & row_lu) | (sen4 & row_lp);
  wire in_hit = (even_sel & even_hit) | (odd_sel & odd_hit);

  // Write set and clear conditions for both word streams
  wire o_set = punch_fn & out_word_p & half_q;
  wire i_set = sense_en & half_q & wset_p & in_hit & ~o_set;
  wire o_clr = punch_fn & half_q & rdstop_q & wclr_p;
  wire i_clr = ~rdstop_q & wclr_p;

  // Write and read-stop flops; a set always beats a clear
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      write_q <= 1'b0;
      rdstop_q <= 1'b0;
      o_group_step <= 1'b0;
    end else begin
      o_group_step <= 1'b0;
      if (o_set) begin
        write_q <= 1'b1;
        rdstop_q <= 1'b1;
      end else if (i_set) begin
        write_q <= 1'b1;
        rdstop_q <= 1'b0;
      end else if (write_q & o_clr) begin
        write_q <= 1'b0;
      end else if (write_q & i_clr) begin
        write_q <= 1'b0;
        o_group_step <= 1'b1;
      end
    end
  end

  // Read-stop line is low from an output-word set until the next input-word set
  assign o_read_stop_level = ~rdstop_q;
  assign o_write_ff = write_q;
  assign o_read_ff = read_q;

  // Transfer set condition, limited to twenty words from address 100
  wire x_set = xfer_en & half_q & sen5_p & (xfer_cnt_q < `CBH_XFER_WORDS);
  wire s_set = setup_en & readout_p;

  // Head-one read flop for punch setup and buffer-to-storage transfer
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      read_q <= 1'b0;
      o_upper_half_store_strobe <= 1'b0;
    end else begin
      o_upper_half_store_strobe <= x_set;
      if (s_set | x_set) begin
        read_q <= 1'b1;
      end else if (setup_en & half_q & rev_one) begin
        read_q <= 1'b0;
      end else if (xfer_en & word_done_p) begin
        read_q <= 1'b0;
      end
    end
  end

  // Event counters, cleared from software
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      in_cnt_q <= `CBH_CNT_RST;
      xfer_cnt_q <= `CBH_CNT_RST;
    end else if (clr_cnt_q) begin
      in_cnt_q <= `CBH_CNT_RST;
      xfer_cnt_q <= `CBH_CNT_RST;
    end else begin
      if (i_set) begin
        in_cnt_q <= in_cnt_q + 8'h01;
      end
      if (x_set) begin
        xfer_cnt_q <= xfer_cnt_q + 8'h01;
      end
    end
  end

  // Gate enables registered from head state
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      o_head1_punch_write <= 1'b0;
      o_head1_reader_gate <= 1'b1; // Cleared half puts reader area under head one
      o_head1_punch_gate <= 1'b0;
      o_head2_punch_read_gate <= 1'b1;
      o_head2_reader_rw_gate <= 1'b0;
      o_head2_write_gate <= 1'b0;
    end else begin
      o_head1_punch_write <= write_q & pedestal & wr_gate & half_q;
      o_head1_reader_gate <= ~half_q;
      o_head1_punch_gate <= half_q;
      o_head2_punch_read_gate <= ~half_q;
      o_head2_reader_rw_gate <= half_q;
      o_head2_write_gate <= half_q & h2_wreq;
    end
  end

  // AXI4-Lite write side
  reg aw_have_q;
  reg w_have_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;

  assign o_awready = ~aw_have_q & ~bvalid_q;
  assign o_wready = ~w_have_q & ~bvalid_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;

  wire wr_go = aw_have_q & w_have_q & ~bvalid_q;

  // Capture address and data in either order, answer once both are held
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `CBH_RESP_OK;
    end else begin
      if (i_awvalid & o_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= i_awaddr;
      end
      if (i_wvalid & o_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= addr_ok(awaddr_q) ? `CBH_RESP_OK : `CBH_RESP_ERR;
      end else if (bvalid_q & i_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Control register write and one-cycle count clear
  wire ctrl_wr = wr_go & (awaddr_q == `CBH_CTRL_OFF) & wstrb_q[0];

  always @(posedge i_clk) begin
    if (!i_rstn) begin
      ctrl_q <= `CBH_CTRL_RST;
      clr_cnt_q <= 1'b0;
    end else begin
      clr_cnt_q <= ctrl_wr & wdata_q[`CBH_C_CLR];
      if (ctrl_wr) begin
        ctrl_q <= wdata_q[`CBH_CTRL_W-1:0];
      end
    end
  end

  // AXI4-Lite read side
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  reg [31:0] rd_mux;

  assign o_arready = ~rvalid_q;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;

  // Read data select, unused bits read as zero
  always @* begin
    rd_mux = 32'h0000_0000;
    case (i_araddr)
      `CBH_CTRL_OFF: begin
        rd_mux[`CBH_CTRL_W-1:0] = ctrl_q;
      end
      `CBH_STAT_OFF: begin
        rd_mux[`CBH_S_HALF] = half_q;
        rd_mux[`CBH_S_RDSTOP] = rdstop_q;
        rd_mux[`CBH_S_WRITE] = write_q;
        rd_mux[`CBH_S_READ] = read_q;
      end
      `CBH_CNT_OFF: begin
        rd_mux[15:0] = {xfer_cnt_q, in_cnt_q};
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Read answer one cycle after the address is taken
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `CBH_RESP_OK;
    end else if (i_arvalid & o_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= addr_ok(i_araddr) ? `CBH_RESP_OK : `CBH_RESP_ERR;
    end else if (rvalid_q & i_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

// File: logic/cbh_consts.vh
// Constants for the card buffer head-one control block
// Behaviour
// - Output and input words share write period
// - Output-word write sets the read-stop flop
// - Input-word write clears the read-stop flop
// - Mid-word address digit sets or clears half
// - Half flag drives reader and punch outputs
// - Half flag holds, flips each half revolution
// - Head one writes punch area, head two reader
// - Heads alternate between the two buffer areas
// - Head two gating reversed from head one
// - Punch-half write needs flop, pedestal, gates
// - Punch setup sets read flop from readout
// - Punch setup clears read on half and count
// - Transfer sets read on fifth sentinel, twenty
// - Transfer clears read after each word
// - Even: third sentinel, upper unprimed rows
// - Even: fourth sentinel, upper primed rows
// - Even: first sentinel, lower unprimed rows
// - Even: second sentinel, lower primed rows
// - Odd selection swaps the sentinel fields
// - Input write set and clear phases, steps
`ifndef CBH_CONSTS_VH
`define CBH_CONSTS_VH
// Register byte offsets
`define CBH_CTRL_OFF 8'h00
`define CBH_STAT_OFF 8'h04
`define CBH_CNT_OFF 8'h08
// Control fields
`define CBH_C_SENSE 0
`define CBH_C_SETUP 1
`define CBH_C_XFER 2
`define CBH_C_EVEN 3
`define CBH_C_ODD 4
`define CBH_C_SORT 5
`define CBH_C_CLR 6
`define CBH_CTRL_W 6
`define CBH_CTRL_RST 6'h00
// Status fields
`define CBH_S_HALF 0
`define CBH_S_RDSTOP 1
`define CBH_S_WRITE 2
`define CBH_S_READ 3
// Counts
`define CBH_XFER_WORDS 8'h14
`define CBH_CNT_RST 8'h00
// Bus answers
`define CBH_RESP_OK 2'h0
`define CBH_RESP_ERR 2'h2
// Synchronised pin count
`define CBH_NPIN 21
`endif

// File: test/cbh_properties.sv
// Port checker for the head-one buffer control block
`timescale 1ns/10ps
module cbh_properties (
  // Clock, reset and timing pins
  input wire i_clk,
  input wire i_rstn,
  input wire i_timing_msd_signal,
  input wire i_address_sample_phase,
  // Watched outputs
  input wire o_reader_half_under_head,
  input wire o_punch_half_under_head,
  input wire o_read_stop_level,
  input wire o_write_ff,
  input wire o_read_ff,
  input wire o_group_step,
  input wire o_upper_half_store_strobe,
  input wire o_head1_punch_write,
  input wire o_head1_reader_gate,
  input wire o_head1_punch_gate,
  input wire o_head2_punch_read_gate,
  input wire o_head2_reader_rw_gate,
  input wire o_head2_write_gate
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // Address sample edges seeing digit 1 and digit 0
  sequence s_digit_one;
    $rose(i_address_sample_phase) && !i_timing_msd_signal;
  endsequence
  sequence s_digit_zero;
    $rose(i_address_sample_phase) && i_timing_msd_signal;
  endsequence
  a_half_set: assert property (s_digit_one |-> ##[1:6] o_reader_half_under_head)
    else $error("half flag not set");
  a_half_clear: assert property (s_digit_zero |-> ##[1:6] !o_reader_half_under_head)
    else $error("half flag not cleared");
  a_half_compl: assert property (o_reader_half_under_head ^ o_punch_half_under_head)
    else $error("half outputs not complementary");
  a_gate_lag: assert property (o_head1_punch_gate == $past(o_reader_half_under_head))
    else $error("head one punch gate off half");
  a_gate_reverse: assert property (o_head1_reader_gate == !o_head1_punch_gate &&
    o_head2_punch_read_gate == o_head1_reader_gate && o_head2_reader_rw_gate == o_head1_punch_gate)
    else $error("head gates not reversed");
  a_stop_with_write: assert property ($changed(o_read_stop_level) |-> o_write_ff)
    else $error("read stop moved without write");
  a_step_cause: assert property (o_group_step |-> $fell(o_write_ff) && o_read_stop_level)
    else $error("group step without input clear");
  a_step_pulse: assert property (o_group_step |=> !o_group_step)
    else $error("group step too long");
  a_strobe_set: assert property (o_upper_half_store_strobe |-> o_read_ff && !$past(o_upper_half_store_strobe))
    else $error("store strobe without read set");
  a_punch_write: assert property (o_head1_punch_write |-> $past(o_write_ff) && $past(o_reader_half_under_head))
    else $error("punch write without write flop");
  a_head2_area: assert property (o_head2_write_gate |-> $past(o_reader_half_under_head))
    else $error("head two write outside reader area");
endmodule
bind cbh_card_buffer_head_one cbh_properties u_props (.*);

// File: test/cbh_drum_model.sv
// Far-side model: drum timing phases and sentinel levels
`timescale 1ns/10ps
module cbh_drum_model #(parameter int WORDS = 20) (
  // Clock and sentinel choice
  input wire i_clk,
  input wire [2:0] i_sel,
  // Timing pins
  output wire o_msd,
  output wire o_sample,
  output wire o_set,
  output wire o_clear,
  output wire [4:0] o_sent
);
  int cyc = 0;
  int word = 0;
  // Twelve clocks a word, two halves of WORDS words a turn
  always @(posedge i_clk) begin
    cyc <= (cyc == 11) ? 0 : cyc + 1;
    if (cyc == 11) begin
      word <= (word == 2 * WORDS - 1) ? 0 : word + 1;
    end
  end
  // Digit 0 reads high over the first half and holds all through it
  assign o_msd = word < WORDS;
  // Phase points inside each word
  assign o_sample = cyc == 0;
  assign o_set = cyc == 5;
  assign o_clear = cyc == 9;
  // Chosen sentinel drops at word edges so every word gives a fresh edge
  assign o_sent = (cyc > 0 && cyc < 11) ? 5'h01 << (i_sel - 3'h1) : 5'h00;
endmodule

// File: test/cbh_card_buffer_head_one_tb_top.sv
// Self-checking bench for the head-one buffer control block
`timescale 1ns/10ps
module cbh_card_buffer_head_one_tb_top;
  logic i_clk = 0, i_rstn = 0;
  logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
  logic [7:0] i_awaddr = 0, i_araddr = 0;
  logic [31:0] i_wdata = 0;
  logic [3:0] i_wstrb = 4'hf;
  logic [3:0] rows = 0;
  logic [2:0] sel = 0;
  wire [4:0] sent;
  wire i_timing_msd_signal, i_address_sample_phase, i_write_set_phase, i_write_clear_phase;
  wire i_sentinel_first = sent[0], i_sentinel_second = sent[1], i_sentinel_third = sent[2];
  wire i_sentinel_fourth = sent[3], i_sentinel_fifth = sent[4];
  wire i_row_upper_unprimed = rows[0], i_row_upper_primed = rows[1];
  wire i_row_lower_unprimed = rows[2], i_row_lower_primed = rows[3];
  logic i_readout_set_level = 0, i_revolution_count_one = 0, i_punch_function = 0, i_output_word_read = 0;
  logic i_word_read_done = 0, i_write_pedestal = 1, i_write_input_gate = 1, i_head2_write_req = 1;
  wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_reader_half_under_head, o_punch_half_under_head;
  wire o_read_stop_level, o_write_ff, o_read_ff, o_group_step, o_upper_half_store_strobe, o_sort_request;
  wire [1:0] o_bresp, o_rresp;
  wire [31:0] o_rdata;
  int error_cnt = 0, n_checks = 0;
  cbh_card_buffer_head_one DUT (.*, .o_head1_punch_write(), .o_head1_reader_gate(), .o_head1_punch_gate(),
    .o_head2_punch_read_gate(), .o_head2_reader_rw_gate(), .o_head2_write_gate());
  cbh_drum_model u_drum (.i_clk(i_clk), .i_sel(sel), .o_msd(i_timing_msd_signal),
    .o_sample(i_address_sample_phase), .o_set(i_write_set_phase), .o_clear(i_write_clear_phase), .o_sent(sent));
  // Clock
  initial forever #50 i_clk = ~i_clk;
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    i_awvalid <= 1;
    i_awaddr <= a;
    i_wvalid <= 1;
    i_wdata <= d;
    i_bready <= 1;
    do begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 0;
      if (o_wready) i_wvalid <= 0;
    end while (!o_bvalid);
    i_bready <= 0;
    chk(o_bresp, er);
    @(posedge i_clk); // Idle edge before the next request
  endtask
  // Bus read
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    i_arvalid <= 1;
    i_araddr <= a;
    i_rready <= 1;
    do begin
      @(posedge i_clk);
      if (o_arready) i_arvalid <= 0;
    end while (!o_rvalid);
    i_rready <= 0;
    chk(o_rdata, ed);
    chk(o_rresp, er);
    @(posedge i_clk); // Idle edge before the next request
  endtask
  // Wait for the half flag to reach a level
  task automatic wh(input logic v);
    int n = 0;
    while (o_reader_half_under_head !== v && n < 2000) begin
      @(posedge i_clk);
      n++;
    end
    chk(o_reader_half_under_head, v);
  endtask
  // Reset levels, unmapped place, sort bit
  task automatic t_reset;
    chk({o_reader_half_under_head, o_punch_half_under_head, o_read_stop_level}, 3'b011);
    rd(8'h04, 0, 0);
    rd(8'h0c, 0, 2);
    wr(8'h20, 1, 2);
    wr(8'h00, 8'h20, 0);
    chk(o_sort_request, 1);
    rd(8'h00, 8'h20, 0);
    wr(8'h00, 0, 0);
  endtask
  // Half flag follows the address digit
  task automatic t_half;
    wh(1);
    rd(8'h04, 1, 0);
    wh(0);
    rd(8'h04, 0, 0);
  endtask
  // Output word from storage lowers the read-stop level
  task automatic t_output;
    i_punch_function <= 1;
    wh(1);
    i_output_word_read <= 1;
    repeat (2) @(posedge i_clk);
    i_output_word_read <= 0;
    repeat (6) @(posedge i_clk);
    chk(o_read_stop_level, 0);
    i_punch_function <= 0;
  endtask
  // Input-word sets per group, row and sentinel over one punch half
  task automatic t_groups;
    logic [11:0] tab [9] = '{12'h013, 12'h024, 12'h041, 12'h082, 12'h111, 12'h122, 12'h143, 12'h184, 12'h011};
    for (int i = 0; i < 9; i++) begin
      wh(1);
      wh(0);
      wr(8'h00, tab[i][8] ? 8'h51 : 8'h49, 0);
      rows <= tab[i][7:4];
      sel <= tab[i][2:0];
      wh(1);
      wh(0);
      wr(8'h00, 0, 0);
      rd(8'h08, (i < 8) ? 8'h14 : 8'h00, 0);
    end
    chk(o_read_stop_level, 1);
    rows <= 0;
  endtask
  // Transfer reads: one set per fifth sentinel, twenty at most
  task automatic t_xfer;
    int n = 0;
    wh(1);
    wh(0);
    wr(8'h00, 8'h44, 0);
    sel <= 5;
    repeat (1000) begin
      @(posedge i_clk);
      i_word_read_done <= o_read_ff;
      n += o_upper_half_store_strobe;
    end
    rd(8'h08, 16'h1400, 0);
    chk(n, 20);
    sel <= 0;
    wr(8'h00, 0, 0);
    chk(o_read_ff, 0);
  endtask
  // Punch setup: readout sets, punch half with count one clears
  task automatic t_setup;
    wh(1);
    wh(0);
    wr(8'h00, 8'h02, 0);
    i_readout_set_level <= 1;
    repeat (6) @(posedge i_clk);
    chk(o_read_ff, 1);
    i_revolution_count_one <= 1;
    repeat (6) @(posedge i_clk);
    chk(o_read_ff, 1);
    wh(1);
    repeat (6) @(posedge i_clk);
    chk(o_read_ff, 0);
    i_readout_set_level <= 0;
    i_revolution_count_one <= 0;
    wr(8'h00, 0, 0);
  endtask
  // Verdict and end of run
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (30000) @(posedge i_clk);
    error_cnt++;
    close_out;
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge i_clk);
    i_rstn <= 1;
    @(posedge i_clk);
    t_reset;
    t_half;
    t_output;
    t_groups;
    t_xfer;
    t_setup;
    close_out;
  end
endmodule
